// ---- rtl/pdkc_pkg.sv ----
// Constants, carrier types and states for the pulse dialler control block.
// Assumes a 25 MHz system clock and an AXI4-Lite register master.
package pdkc_pkg;

    // AXI4-Lite carriers
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } pdkc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pdkc_axi_rsp_t;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    localparam int CTRL_MS_BIT  = 0;
    localparam int CTRL_RS0_BIT = 1;
    localparam int CTRL_RS1_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    localparam int ST_HOOK_BIT    = 0;
    localparam int ST_STANDBY_BIT = 1;
    localparam int ST_MUTE_BIT    = 2;
    localparam int ST_LINE_BIT    = 3;
    localparam int ST_PAUSE_BIT   = 4;
    localparam int ST_EXTHOLD_BIT = 5;
    localparam int ST_FSM_LSB     = 8;
    localparam int ST_WR_LSB      = 16;
    localparam int ST_RD_LSB      = 24;

    // Redial memory
    localparam int MEM_DEPTH = 23;
    localparam int PTR_W     = 5;

    // Key codes, index = row * 3 + column, one nibble each
    localparam logic [47:0] KEY_MAP    = 48'hCAB987654321;
    localparam logic [3:0]  KEY_PAUSE  = 4'hB;
    localparam logic [3:0]  KEY_REDIAL = 4'hC;

    // Timebase
    localparam int MCLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 72464;
    localparam int TICK_DIV_DEF   = TICK_PERIOD_NS / MCLK_PERIOD_NS;

    // One dial pulse period is 15 slots
    localparam logic [4:0] PERIOD_SLOTS  = 5'h0F;
    localparam logic [4:0] MARK_SLOTS_32 = 5'h09;
    localparam logic [4:0] MARK_SLOTS_21 = 5'h0A;
    localparam logic [4:0] BRK_SLOTS     = 5'h18;

    // Slot length in ticks per rate
    localparam logic [6:0] SLOT_10PPS  = 7'h5C;
    localparam logic [6:0] SLOT_20PPS  = 7'h2E;
    localparam logic [6:0] SLOT_16PPS  = 7'h39;
    localparam logic [6:0] TEST_FACTOR = 7'h5C;
    localparam logic [6:0] SLOT_TEST   = 7'(SLOT_10PPS / TEST_FACTOR);

    // Keypad debounce in ticks
    localparam logic [2:0] KEY_CLOSE_TICKS = 3'h4;
    localparam logic [2:0] KEY_OPEN_TICKS  = 3'h3;

    // Mute prepulse after wake-up, in ticks
    localparam logic [4:0] PRE_DELAY_TICKS = 5'h0A;
    localparam logic [4:0] PRE_WIDTH_TICKS = 5'h0A;

    // Inter-digit pause and access pause tap, in slots
    localparam int IDP_SLOTS_DEF = 120;
    localparam int TAP_SLOTS_DEF = 465;
    localparam int CNT_W         = 10;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_IDP,
        ST_MARK,
        ST_SPACE,
        ST_PAUSE
    } pdkc_state_t;

endpackage

// ---- rtl/pdkc_top.sv ----
// Pulse dialler control: hook filter, keypad debounce, redial memory,
// pulse generation and access pause, with an AXI4-Lite register slave.
// Assumes all pins synchronous to mclk; pause hold is an open pin.
//
// Operation
// - Mark-to-space 3:2 with ratio bit high, else 2:1.
// - Standby holds all in reset but the write pointer, memory and register slave.
// - Standby ignores keys, keeps stored digits.
// - Hook high runs timebase, releases logic, takes keys.
// - Hook low past break filter time resets into standby.
// - Shorter hook lows are ignored.
// - Valid key: one column high, one row low.
// - Key stored as 4-bit code after four closed ticks.
// - Next key refused until open three ticks.
// - Memory holds up to 23 digits.
// - Pause code drives pause hold high, stops dialling.
// - External hold stops after digit, or at once in gap.
// - Rate set by the two rate-select bits.
// - Break filter time is 1.6 dial pulse periods.
// - Rate select 0 high, 1 low: test mode, 92x rate.
// - Mute high once a key is stored.
// - Pulse digits, bump read pointer until pointers equal.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pdkc_top #(
    parameter int TICK_DIV  = pdkc_pkg::TICK_DIV_DEF,
    parameter int IDP_SLOTS = pdkc_pkg::IDP_SLOTS_DEF,
    parameter int TAP_SLOTS = pdkc_pkg::TAP_SLOTS_DEF
) (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire pdkc_pkg::pdkc_axi_req_t axi_req,
    output      pdkc_pkg::pdkc_axi_rsp_t axi_rsp,
    input  wire logic                    hook_en,
    input  wire logic [2:0]              column_in,
    input  wire logic [3:0]              row_in,
    input  wire logic                    pause_hold_in,
    output      logic                    pause_hold_out,
    output      logic                    pause_hold_oe,
    output      logic                    line_pulse_out,
    output      logic                    mute_out
);
    import pdkc_pkg::*;

    localparam int TW = $clog2(TICK_DIV);

    logic [2:0]       ctrl_q;
    logic             awgot_q;
    logic             wgot_q;
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    logic [31:0]      status;
    logic             standby_q;
    logic [4:0]       brk_cnt_q;
    logic [TW-1:0]    tick_cnt_q;
    logic             tick;
    logic [6:0]       slot_len;
    logic [6:0]       slot_cnt_q;
    logic             slot;
    logic             key_valid;
    logic             key_open;
    logic [1:0]       key_row;
    logic [1:0]       key_col;
    logic [3:0]       key_idx;
    logic [3:0]       key_code;
    logic [2:0]       kb_cnt_q;
    logic [3:0]       kb_code_q;
    logic             kb_armed_q;
    logic             key_stb_q;
    logic [3:0]       key_code_q;
    logic             fresh_q;
    logic             store_ok;
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W-1:0] rd_next;
    logic [3:0]       mem_q [MEM_DEPTH];
    logic [3:0]       rd_code;
    pdkc_state_t      state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [3:0]       pulses_q;
    logic [4:0]       mark_slots;
    logic [4:0]       space_slots;
    logic             ext_hold;
    logic             dial_mute_q;
    logic             line_q;
    logic             pause_q;
    logic [4:0]       pre_cnt_q;
    logic             pre_q;
    logic             last_digit;

    // Bus slave: write side
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            awgot_q   <= 1'b0;
            wgot_q    <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            ctrl_q    <= CTRL_RESET;
        end else begin
            awready_q <= !awgot_q && !bvalid_q
                         && !(axi_req.awvalid && awready_q);
            wready_q  <= !wgot_q && !bvalid_q
                         && !(axi_req.wvalid && wready_q);
            if (axi_req.awvalid && awready_q) begin
                awgot_q  <= 1'b1;
                awaddr_q <= axi_req.awaddr;
            end
            if (axi_req.wvalid && wready_q) begin
                wgot_q  <= 1'b1;
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end
            if (awgot_q && wgot_q && !bvalid_q) begin
                awgot_q  <= 1'b0;
                wgot_q   <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == REG_CTRL || awaddr_q == REG_STATUS)
                           ? RESP_OKAY : RESP_SLVERR;
                if (awaddr_q == REG_CTRL && wstrb_q[0]) begin
                    ctrl_q <= wdata_q[2:0];
                end
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[ST_HOOK_BIT]    = hook_en;
        status[ST_STANDBY_BIT] = standby_q;
        status[ST_MUTE_BIT]    = mute_out;
        status[ST_LINE_BIT]    = line_q;
        status[ST_PAUSE_BIT]   = pause_q;
        status[ST_EXTHOLD_BIT] = ext_hold;
        status[ST_FSM_LSB +: 3]   = state_q;
        status[ST_WR_LSB +: PTR_W] = wr_q;
        status[ST_RD_LSB +: PTR_W] = rd_q;
    end

    // Bus slave: read side
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else begin
            arready_q <= !rvalid_q && !(axi_req.arvalid && arready_q);
            if (axi_req.arvalid && arready_q) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OKAY;
                if (axi_req.araddr == REG_CTRL) begin
                    rdata_q <= {29'h0000_0000, ctrl_q};
                end else if (axi_req.araddr == REG_STATUS) begin
                    rdata_q <= status;
                end else begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            end else if (rvalid_q && axi_req.rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign axi_rsp = '{awready: awready_q, wready: wready_q,
                       bresp: bresp_q, bvalid: bvalid_q,
                       arready: arready_q, rdata: rdata_q,
                       rresp: rresp_q, rvalid: rvalid_q};

    // Hook filter; standby acts as the internal reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            standby_q <= 1'b1;
            brk_cnt_q <= 5'h00;
        end else if (hook_en) begin
            standby_q <= 1'b0;
            brk_cnt_q <= 5'h00;
        end else if (!standby_q && slot) begin
            if (brk_cnt_q == BRK_SLOTS - 5'h01) begin
                standby_q <= 1'b1;
                brk_cnt_q <= 5'h00;
            end else begin
                brk_cnt_q <= brk_cnt_q + 5'h01;
            end
        end
    end

    // Rate selection
    always_comb begin
        if (ctrl_q[CTRL_RS1_BIT] && ctrl_q[CTRL_RS0_BIT]) begin
            slot_len = SLOT_16PPS;
        end else if (ctrl_q[CTRL_RS1_BIT]) begin
            slot_len = SLOT_20PPS;
        end else if (ctrl_q[CTRL_RS0_BIT]) begin
            slot_len = SLOT_TEST;
        end else begin
            slot_len = SLOT_10PPS;
        end
    end

    // Timebase, stopped in standby
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_q <= '0;
            slot_cnt_q <= 7'h00;
        end else if (standby_q) begin
            tick_cnt_q <= '0;
            slot_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
            if (slot) begin
                slot_cnt_q <= 7'h00;
            end else if (tick) begin
                slot_cnt_q <= slot_cnt_q + 7'h01;
            end
        end
    end

    assign tick = (tick_cnt_q == TW'(TICK_DIV - 1));
    assign slot = tick && (slot_cnt_q >= slot_len - 7'h01);

    // Keypad decode
    always_comb begin
        key_row = 2'h0;
        key_col = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (!row_in[i]) begin
                key_row = 2'(i);
            end
        end
        for (int j = 0; j < 3; j++) begin
            if (column_in[j]) begin
                key_col = 2'(j);
            end
        end
    end

    assign key_valid = $onehot(column_in) && $onehot(~row_in);
    assign key_open  = (column_in == 3'h0) && (&row_in);
    assign key_idx   = 4'({2'h0, key_row} * 4'h3) + {2'h0, key_col};
    assign key_code  = KEY_MAP[{key_idx, 2'h0} +: 4];

    // Debounce on both edges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            kb_cnt_q   <= 3'h0;
            kb_code_q  <= 4'h0;
            kb_armed_q <= 1'b1;
            key_stb_q  <= 1'b0;
            key_code_q <= 4'h0;
        end else if (standby_q || !hook_en) begin
            kb_cnt_q   <= 3'h0;
            kb_code_q  <= 4'h0;
            kb_armed_q <= 1'b1;
            key_stb_q  <= 1'b0;
        end else begin
            key_stb_q <= 1'b0;
            if (tick && kb_armed_q) begin
                if (key_valid && key_code == kb_code_q
                    && kb_cnt_q != 3'h0) begin
                    if (kb_cnt_q == KEY_CLOSE_TICKS - 3'h1) begin
                        key_stb_q  <= 1'b1;
                        key_code_q <= kb_code_q;
                        kb_armed_q <= 1'b0;
                        kb_cnt_q   <= 3'h0;
                    end else begin
                        kb_cnt_q <= kb_cnt_q + 3'h1;
                    end
                end else if (key_valid) begin
                    kb_code_q <= key_code;
                    kb_cnt_q  <= 3'h1;
                end else begin
                    kb_cnt_q <= 3'h0;
                end
            end else if (tick) begin
                if (!key_open) begin
                    kb_cnt_q <= 3'h0;
                end else if (kb_cnt_q == KEY_OPEN_TICKS - 3'h1) begin
                    kb_armed_q <= 1'b1;
                    kb_cnt_q   <= 3'h0;
                end else begin
                    kb_cnt_q <= kb_cnt_q + 3'h1;
                end
            end
        end
    end

    // Redial memory and write pointer, untouched by standby
    assign store_ok = key_stb_q && key_code_q != KEY_REDIAL
                      && (fresh_q || wr_q != PTR_W'(MEM_DEPTH));

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
        end else if (store_ok) begin
            wr_q <= fresh_q ? PTR_W'(1) : wr_q + PTR_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (store_ok) begin
            mem_q[fresh_q ? '0 : wr_q] <= key_code_q;
        end
    end

    // First key after standby starts a new number or a redial
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fresh_q <= 1'b1;
        end else if (standby_q) begin
            fresh_q <= 1'b1;
        end else if (key_stb_q) begin
            fresh_q <= 1'b0;
        end
    end

    assign rd_code     = mem_q[rd_q];
    assign rd_next     = rd_q + PTR_W'(1);
    assign last_digit  = (rd_next == wr_q);
    assign ext_hold    = pause_hold_in && !pause_q && !pause_hold_oe;
    assign mark_slots  = ctrl_q[CTRL_MS_BIT] ? MARK_SLOTS_32 
                                             : MARK_SLOTS_21;
    assign space_slots = PERIOD_SLOTS - mark_slots;

    // Dialling sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= ST_IDLE;
            rd_q        <= '0;
            cnt_q       <= '0;
            pulses_q    <= 4'h0;
            dial_mute_q <= 1'b0;
            line_q      <= 1'b0;
            pause_q     <= 1'b0;
        end else if (standby_q) begin
            state_q     <= ST_IDLE;
            rd_q        <= '0;
            cnt_q       <= '0;
            pulses_q    <= 4'h0;
            dial_mute_q <= 1'b0;
            line_q      <= 1'b0;
            pause_q     <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (!fresh_q && rd_q != wr_q) begin
                        dial_mute_q <= 1'b1;
                        cnt_q       <= '0;
                        state_q     <= ST_IDP;
                    end
                end
                ST_IDP: begin
                    if (slot && !ext_hold) begin
                        if (cnt_q == CNT_W'(IDP_SLOTS - 1)) begin
                            cnt_q <= '0;
                            if (rd_code == KEY_PAUSE) begin
                                pause_q <= 1'b1;
                                state_q <= ST_PAUSE;
                            end else begin
                                pulses_q <= rd_code;
                                line_q   <= 1'b1;
                                state_q  <= ST_MARK;
                            end
                        end else begin
                            cnt_q <= cnt_q + CNT_W'(1);
                        end
                    end
                end
                ST_MARK: begin
                    if (slot) begin
                        if (cnt_q == CNT_W'(mark_slots - 5'h01)) begin
                            cnt_q   <= '0;
                            line_q  <= 1'b0;
                            state_q <= ST_SPACE;
                        end else begin
                            cnt_q <= cnt_q + CNT_W'(1);
                        end
                    end
                end
                ST_SPACE: begin
                    if (slot) begin
                        if (cnt_q == CNT_W'(space_slots - 5'h01)) begin
                            cnt_q <= '0;
                            if (pulses_q == 4'h1) begin
                                rd_q        <= rd_next;
                                dial_mute_q <= !last_digit;
                                state_q     <= last_digit ? ST_IDLE : ST_IDP;
                            end else begin
                                pulses_q <= pulses_q - 4'h1;
                                line_q   <= 1'b1;
                                state_q  <= ST_MARK;
                            end
                        end else begin
                            cnt_q <= cnt_q + CNT_W'(1);
                        end
                    end
                end
                ST_PAUSE: begin
                    // Ends on tap, any key, or pin forced low once driven
                    if (key_stb_q || (pause_hold_oe && !pause_hold_in)
                        || (slot && cnt_q == CNT_W'(TAP_SLOTS - 1))) begin
                        pause_q     <= 1'b0;
                        cnt_q       <= '0;
                        rd_q        <= rd_next;
                        dial_mute_q <= !last_digit;
                        state_q     <= last_digit ? ST_IDLE : ST_IDP;
                    end else if (slot) begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Mute prepulse after wake-up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_q <= 5'h00;
            pre_q     <= 1'b0;
        end else if (standby_q) begin
            pre_cnt_q <= 5'h00;
            pre_q     <= 1'b0;
        end else if (tick && pre_cnt_q != 5'h1F) begin
            if (pre_cnt_q == PRE_DELAY_TICKS - 5'h01) begin
                pre_q <= 1'b1;
            end else if (pre_cnt_q == PRE_DELAY_TICKS
                         + PRE_WIDTH_TICKS - 5'h01) begin
                pre_q <= 1'b0;
            end
            pre_cnt_q <= pre_cnt_q + 5'h01;
        end
    end

    // Output flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mute_out       <= 1'b0;
            line_pulse_out <= 1'b0;
            pause_hold_out <= 1'b0;
            pause_hold_oe  <= 1'b0;
        end else begin
            mute_out       <= dial_mute_q || pre_q;
            line_pulse_out <= line_q;
            pause_hold_out <= pause_q;
            pause_hold_oe  <= pause_q;
        end
    end

endmodule

// ---- tb/pdkc_checker.sv ----
// Port assertions for the pulse dialler control block.
// Bound into pdkc_top; one clock domain.
`timescale 1ns/1ps
module pdkc_checker (
    input wire logic                    mclk,
    input wire logic                    nrst,
    input wire pdkc_pkg::pdkc_axi_req_t axi_req,
    input wire pdkc_pkg::pdkc_axi_rsp_t axi_rsp,
    input wire logic                    pause_hold_out,
    input wire logic                    pause_hold_oe,
    input wire logic                    line_pulse_out,
    input wire logic                    mute_out
);
    import pdkc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    line_mute_a: assert property (line_pulse_out |-> mute_out)
        else $error("line pulse while unmuted");
    pause_drive_a: assert property (pause_hold_oe |-> pause_hold_out)
        else $error("pause pin driven low");
    pause_stop_a: assert property (
        pause_hold_oe |-> !$rose(line_pulse_out))
        else $error("pulse during pause");
    write_resp_a: assert property (wr_take |-> ##[1:3] axi_rsp.bvalid)
        else $error("no write response");
    read_resp_a: assert property (rd_take |=> axi_rsp.rvalid)
        else $error("no read response");
    bad_addr_a: assert property (
        rd_take and axi_req.araddr > REG_STATUS |=>
        axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
endmodule
bind pdkc_top pdkc_checker u_pdkc_checker (
    .mclk(mclk), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .pause_hold_out(pause_hold_out), .pause_hold_oe(pause_hold_oe),
    .line_pulse_out(line_pulse_out), .mute_out(mute_out));

// ---- tb/pdkc_keypad.sv ----
// Keypad matrix and pause pin seen from outside the dialler.
// Idle columns low, rows high, pause pin pulled low.
`timescale 1ns/1ps
module pdkc_keypad (
    input  wire logic [3:0] key,
    input  wire logic       press,
    input  wire logic       bad,
    input  wire logic       pin_out,
    input  wire logic       pin_oe,
    output      logic [2:0] column_in,
    output      logic [3:0] row_in,
    output      logic       pin_lvl
);
    always_comb begin
        column_in = press ? 3'(3'h1 << (key % 4'h3)) : 3'h0;
        row_in    = press ? ~4'(4'h1 << (key / 4'h3)) : 4'hF;
        // First column closed at once
        if (bad)
            column_in = column_in | 3'h1;
    end
    assign pin_lvl = pin_oe ? pin_out : 1'b0;
endmodule

// ---- tb/pdkc_top_test.sv ----
// Self-checking bench for pdkc_top with a short timebase.
// Keypad and pause pin far side come from pdkc_keypad.
`timescale 1ns/1ps
module pdkc_top_test;
    import pdkc_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d, m, e;
        logic [1:0]  rw, rr;
    } pdkc_row_t;
    pdkc_row_t     rows [4] = '{
        '{REG_STATUS, 32'hFF, 32'h3, 32'h1, RESP_OKAY, RESP_OKAY},
        '{8'h08, 32'h1, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, RESP_SLVERR},
        '{REG_CTRL, 32'h5, 32'h7, 32'h5, RESP_OKAY, RESP_OKAY},
        '{REG_CTRL, 32'h3, 32'h7, 32'h3, RESP_OKAY, RESP_OKAY}};
    logic          mclk = 1'b0, nrst = 1'b0, hook_en = 1'b1;
    logic          press = 1'b0, bad = 1'b0, pin_lvl;
    logic [3:0]    key = 4'h0, row_in;
    logic [2:0]    column_in;
    logic          pause_hold_out, pause_hold_oe, line_pulse_out, mute_out;
    logic [31:0]   s, wr0;
    logic [1:0]    r;
    pdkc_axi_req_t axi_req = '0;
    pdkc_axi_rsp_t axi_rsp;
    int            miscompares = 0, checked = 0;
    int            run = 0, width = 0, pulses = 0, i;
    always #20 mclk = ~mclk;
    pdkc_top #(.TICK_DIV(4), .IDP_SLOTS(4), .TAP_SLOTS(8)) u_pdkc_top (
        .mclk(mclk), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .hook_en(hook_en), .column_in(column_in), .row_in(row_in),
        .pause_hold_in(pin_lvl), .pause_hold_out(pause_hold_out),
        .pause_hold_oe(pause_hold_oe), .line_pulse_out(line_pulse_out),
        .mute_out(mute_out));
    pdkc_keypad u_pdkc_keypad (
        .key(key), .press(press), .bad(bad), .pin_out(pause_hold_out),
        .pin_oe(pause_hold_oe), .column_in(column_in), .row_in(row_in),
        .pin_lvl(pin_lvl));
    // Mark length in mclk cycles and pulse count
    always @(posedge mclk) begin
        if (line_pulse_out) run <= run + 1;
        else if (run != 0) begin
            width <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw = 1'b0, w = 1'b0;
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        {axi_req.awvalid, axi_req.wvalid} <= 2'h3;
        while (!(aw && w)) begin
            @(posedge mclk);
            if (axi_req.awvalid && axi_rsp.awready) aw = 1'b1;
            if (axi_req.wvalid && axi_rsp.wready) w = 1'b1;
            {axi_req.awvalid, axi_req.wvalid} <= {!aw, !w};
        end
        while (!axi_rsp.bvalid) @(posedge mclk);
        axi_req.bready <= 1'b1;
        @(posedge mclk);
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        do @(posedge mclk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        while (!axi_rsp.rvalid) @(posedge mclk);
        axi_req.rready <= 1'b1;
        @(posedge mclk);
        {s, r} = {axi_rsp.rdata, axi_rsp.rresp};
        axi_req.rready <= 1'b0;
    endtask
    task automatic push(input logic [3:0] k, input logic b, input int t);
        {key, bad, press} <= {k, b, 1'b1};
        repeat (t * 4) @(posedge mclk);
        {bad, press} <= 2'h0;
        repeat (24) @(posedge mclk);
    endtask
    task automatic dial(input int n, input int w);
        for (i = 0; i < 2000 && mute_out !== 1'b0; i++) @(posedge mclk);
        check(pulses, n);
        check(width, w);
        pulses = 0;
    endtask
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (100) @(posedge mclk);
        axi_rd(REG_CTRL);
        check(s & 32'h7, 32'(CTRL_RESET));
        foreach (rows[j]) begin
            axi_wr(rows[j].a, rows[j].d);
            check(r, rows[j].rw);
            axi_rd(rows[j].a);
            check(s & rows[j].m, rows[j].e);
            check(r, rows[j].rr);
        end
        axi_rd(REG_STATUS);
        wr0 = s[20:16];
        push(4'h2, 1'b0, 2);
        push(4'h4, 1'b1, 8);
        axi_rd(REG_STATUS);
        check(s[20:16], wr0);
        pulses = 0;
        push(4'h2, 1'b0, 8);
        dial(3, 36);
        axi_rd(REG_STATUS);
        check(s[20:16], wr0 + 1);
        axi_wr(REG_CTRL, 32'h2);
        push(4'h1, 1'b0, 8);
        dial(2, 40);
        push(4'h9, 1'b0, 8);
        for (i = 0; i < 400 && pause_hold_oe !== 1'b1; i++) @(posedge mclk);
        check(pause_hold_oe, 1'b1);
        repeat (60) @(posedge mclk);
        check(pause_hold_oe, 1'b0);
        hook_en <= 1'b0;
        repeat (40) @(posedge mclk);
        hook_en <= 1'b1;
        axi_rd(REG_STATUS);
        check(s[1], 1'b0);
        hook_en <= 1'b0;
        axi_rd(REG_STATUS);
        wr0 = s[20:16];
        push(4'h2, 1'b0, 8);
        repeat (60) @(posedge mclk);
        axi_rd(REG_STATUS);
        check(s[1], 1'b1);
        check(s[20:16], wr0);
        hook_en <= 1'b1;
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        check({axi_rsp.awready, mute_out, line_pulse_out}, 3'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        give_verdict;
    end
endmodule
